// ### core/sdp_pkg.sv
// Purpose: Shared constants for the synthesizer divider and power-down register bank.
// Assumes: A 24-bit programming word, MSB first, register-select code in bits 3..0.
// Notes: Rules carried by this block are listed below by tag.
// Function
// - Word is 20 data bits plus 4-bit select.
// - Main word bits 15..4 are denominator low bits.
// - Reference ratio taken directly from bits 21..16.
// - Reference value one is a legal ratio.
// - Bit 22 picks the small or large prescaler.
// - Main power-down bit zero means normal operation.
// - Main power-down one powers down, charge pump floats.
// - Chip-enable low forces main loop down.
// - Auto power-up beats the main power-down bit.
// - Main power-down bit rules only when unforced.
// - Aux power-down bit and chip-enable control aux loop.
// - Auto power-up plus frequency word clears aux down.
package sdp_pkg;

  // Word framing.
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned SEL_BITS = 4;
  localparam int unsigned CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h18;

  // Register-select codes.
  localparam logic [SEL_BITS-1:0] SEL_MAIN_WORD = 4'h3;
  localparam logic [SEL_BITS-1:0] SEL_AUX_WORD = 4'h5;

  // The frequency word is recognised by a clear bit 0 alone.
  localparam int unsigned FREQ_WORD_FLAG_POS = 0;

  // Field positions of the main-loop word.
  localparam int unsigned MAIN_PD_POS = 23;
  localparam int unsigned MAIN_PRESC_POS = 22;
  localparam int unsigned MAIN_REF_MSB = 21;
  localparam int unsigned MAIN_REF_LSB = 16;
  localparam int unsigned MAIN_FD_MSB = 15;
  localparam int unsigned MAIN_FD_LSB = 4;
  localparam int unsigned REF_BITS = 6;
  localparam int unsigned FD_LO_BITS = 12;
  localparam int unsigned FD_HI_BITS = 10;
  localparam int unsigned FD_BITS = 22;

  // Field positions of the auxiliary-loop word.
  localparam int unsigned AUX_PD_POS = 23;
  localparam int unsigned AUX_N_MSB = 22;
  localparam int unsigned AUX_N_LSB = 4;
  localparam int unsigned AUX_N_BITS = 19;

  // Values after reset: both loops parked in power-down.
  localparam logic RST_MAIN_PD = 1'b1;
  localparam logic RST_AUX_PD = 1'b1;
  localparam logic RST_PRESC = 1'b0;
  localparam logic [REF_BITS-1:0] RST_REF = 6'h01;
  localparam logic [FD_LO_BITS-1:0] RST_FD_LO = 12'h000;
  localparam logic [AUX_N_BITS-1:0] RST_AUX_N = 19'h00000;

  // Prescaler choices held by the select bit.
  typedef enum logic {
    SDP_PRESC_SMALL = 1'b0,
    SDP_PRESC_LARGE = 1'b1
  } sdp_presc_t;

endpackage : sdp_pkg

// ### core/sdp_serial_rx.sv
// Purpose: Serial word receiver for 24-bit programming words.
// Assumes: Serial clock, data and latch are synchronous to clk.
// Notes: Data shifts MSB first on serial clock rising edges while latch is low.
`timescale 1ns/100ps
module sdp_serial_rx
  import sdp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  output logic word_valid,
  output logic word_complete,
  output logic [WORD_BITS-1:0] word
);

  // Previous samples for edge detection.
  logic ser_clk_q;
  logic ser_latch_q;
  // Shift register and saturating bit count.
  logic [WORD_BITS-1:0] shift;
  logic [CNT_BITS-1:0] count;

  // Track previous pin levels.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ser_clk_q <= 1'b0;
      ser_latch_q <= 1'b0;
    end else begin
      ser_clk_q <= ser_clk;
      ser_latch_q <= ser_latch;
    end
  end

  // Shift bits in while the latch is low; a latch rising edge restarts the count.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift <= '0;
      count <= '0;
    end else if (ser_latch && !ser_latch_q) begin
      count <= '0;
    end else if (!ser_latch && ser_clk && !ser_clk_q) begin
      shift <= {shift[WORD_BITS-2:0], ser_data};
      if (count != CNT_FULL) begin
        count <= count + 5'h01;
      end
    end
  end

  // Present the word on the latch rising edge; a short word is flagged.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_valid <= 1'b0;
      word_complete <= 1'b0;
      word <= '0;
    end else begin
      word_valid <= ser_latch && !ser_latch_q;
      if (ser_latch && !ser_latch_q) begin
        word <= shift;
        word_complete <= (count == CNT_FULL);
      end
    end
  end

endmodule // sdp_serial_rx

// ### core/sdp_power_ctl.sv
// Purpose: Power state resolution for one synthesizer loop.
// Assumes: Chip enable is active high and synchronous to clk.
// Notes: Outputs are registered, one cycle behind their inputs.
`timescale 1ns/100ps
module sdp_power_ctl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_enable,
  input wire logic force_up,
  input wire logic pd_bit,
  output logic powered,
  output logic cp_hiz
);

  // Resolved power state before the output flops.
  logic next_powered;

  // Chip enable low wins, then the forced power-up, then the stored bit.
  always_comb begin
    if (!chip_enable) begin
      next_powered = 1'b0;
    end else if (force_up) begin
      next_powered = 1'b1;
    end else begin
      next_powered = !pd_bit;
    end
  end

  // The charge pump floats whenever the loop is down.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      powered <= 1'b0;
      cp_hiz <= 1'b1;
    end else begin
      powered <= next_powered;
      cp_hiz <= !next_powered;
    end
  end

endmodule // sdp_power_ctl

// ### core/sdp_regs.sv
// Purpose: Register bank holding the main and auxiliary loop programming words.
// Assumes: Host writes 24-bit words over serial clock, data and latch pins.
// Notes: Fields and power states are held in flops and driven straight out.
`timescale 1ns/100ps
module sdp_regs
  import sdp_pkg::*;
(
  // System clock, 200 MHz.
  input wire logic clk,
  // Synchronous active-low reset.
  input wire logic reset_n,
  // Serial programming pins.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  // Chip-enable pin, high to allow operation.
  input wire logic chip_enable,
  // Auto power-up control, held in another word of the device.
  input wire logic auto_powerup_on_write,
  // Upper denominator bits, held in another word of the device.
  input wire logic [FD_HI_BITS-1:0] main_frac_denominator_hi,
  // Main-loop fields.
  output logic main_loop_powerdown_bit,
  output logic main_prescaler_select,
  output logic [REF_BITS-1:0] main_ref_divider,
  output logic [FD_BITS-1:0] main_frac_denominator,
  // Auxiliary-loop fields.
  output logic aux_loop_powerdown_bit,
  output logic [AUX_N_BITS-1:0] aux_feedback_divider,
  // Resolved power states.
  output logic main_loop_powered,
  output logic main_cp_hiz,
  output logic aux_loop_powered,
  output logic aux_cp_hiz,
  // Status: one-cycle pulse for a short word that was dropped.
  output logic word_rejected
);

  // Received word, its strobe and its completeness.
  logic rx_valid;
  logic rx_complete;
  logic [WORD_BITS-1:0] rx_word;
  // Register-select code of the received word.
  logic [SEL_BITS-1:0] rx_sel;
  // Qualified write strobes for each word.
  logic wr_main;
  logic wr_aux;
  logic wr_freq;
  // Low denominator bits as stored.
  logic [FD_LO_BITS-1:0] fd_lo;
  // Main loop held up by an auto power-up event until the main word is rewritten.
  logic main_auto_up;

  // Serial receiver that frames the programming words.
  sdp_serial_rx u_rx (
    .clk(clk),
    .reset_n(reset_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_latch(ser_latch),
    .word_valid(rx_valid),
    .word_complete(rx_complete),
    .word(rx_word)
  );

  // Select code sits in the lowest four bits of each word.
  assign rx_sel = rx_word[SEL_BITS-1:0];

  // Main and aux strobes fire only for a full word with a matching code; the frequency strobe for a full word with bit 0 clear.
  assign wr_main = rx_valid && rx_complete && (rx_sel == SEL_MAIN_WORD);
  assign wr_aux = rx_valid && rx_complete && (rx_sel == SEL_AUX_WORD);
  assign wr_freq = rx_valid && rx_complete && !rx_word[FREQ_WORD_FLAG_POS];

  // Main-loop word fields; other codes leave them untouched.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_loop_powerdown_bit <= RST_MAIN_PD;
      main_prescaler_select <= RST_PRESC;
      main_ref_divider <= RST_REF;
      fd_lo <= RST_FD_LO;
    end else if (wr_main) begin
      // Power-down bit is the top data bit.
      main_loop_powerdown_bit <= rx_word[MAIN_PD_POS];
      // Zero picks the 16/17/20/21 prescaler, one the 32/33/36/37.
      main_prescaler_select <= rx_word[MAIN_PRESC_POS];
      // Ratio is the binary field itself, so one divides by one.
      main_ref_divider <= rx_word[MAIN_REF_MSB:MAIN_REF_LSB];
      // Low denominator bits.
      fd_lo <= rx_word[MAIN_FD_MSB:MAIN_FD_LSB];
    end
  end

  // Full denominator joins the held upper bits to the stored lower bits.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_frac_denominator <= '0;
    end else begin
      main_frac_denominator <= {main_frac_denominator_hi, fd_lo};
    end
  end

  // Auxiliary-loop word fields.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aux_feedback_divider <= RST_AUX_N;
    end else if (wr_aux) begin
      // Divider sits just above the select code.
      aux_feedback_divider <= rx_word[AUX_N_MSB:AUX_N_LSB];
    end
  end

  // Aux power-down bit: written by its word, cleared by an auto power-up event.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aux_loop_powerdown_bit <= RST_AUX_PD;
    end else if (wr_aux) begin
      aux_loop_powerdown_bit <= rx_word[AUX_PD_POS];
    end else if (wr_freq && auto_powerup_on_write) begin
      aux_loop_powerdown_bit <= 1'b0;
    end
  end

  // Auto power-up of the main loop lasts until the main word takes control again.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_auto_up <= 1'b0;
    end else if (wr_freq && auto_powerup_on_write) begin
      main_auto_up <= 1'b1;
    end else if (wr_main) begin
      main_auto_up <= 1'b0;
    end
  end

  // Dropped short words are reported for one cycle.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word_rejected <= 1'b0;
    end else begin
      word_rejected <= rx_valid && !rx_complete;
    end
  end

  // Main loop power resolution with chip-enable and auto power-up precedence.
  sdp_power_ctl u_main_pwr (
    .clk(clk),
    .reset_n(reset_n),
    .chip_enable(chip_enable),
    .force_up(main_auto_up),
    .pd_bit(main_loop_powerdown_bit),
    .powered(main_loop_powered),
    .cp_hiz(main_cp_hiz)
  );

  // Aux loop power: auto power-up acts by clearing the bit, so no force here.
  sdp_power_ctl u_aux_pwr (
    .clk(clk),
    .reset_n(reset_n),
    .chip_enable(chip_enable),
    .force_up(1'b0),
    .pd_bit(aux_loop_powerdown_bit),
    .powered(aux_loop_powered),
    .cp_hiz(aux_cp_hiz)
  );

endmodule // sdp_regs

// ### dv/sdp_regs_chk.sv
// Purpose: Port assertions for the register bank.
// Assumes: Fields land two cycles after a latch rise, the full denominator three.
// Notes: Power outputs lag their causes by one cycle.
`timescale 1ns/100ps
module sdp_regs_chk
  import sdp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ser_latch,
  input wire logic chip_enable,
  input wire logic [FD_HI_BITS-1:0] main_frac_denominator_hi,
  input wire logic main_loop_powerdown_bit,
  input wire logic [REF_BITS-1:0] main_ref_divider,
  input wire logic [FD_BITS-1:0] main_frac_denominator,
  input wire logic aux_loop_powerdown_bit,
  input wire logic [AUX_N_BITS-1:0] aux_feedback_divider,
  input wire logic main_loop_powered,
  input wire logic main_cp_hiz,
  input wire logic aux_loop_powered,
  input wire logic aux_cp_hiz,
  input wire logic word_rejected
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Previous latch level, used to spot the edge that ends a word.
  logic latch_q;
  logic rise;
  always_ff @(posedge clk) begin
    latch_q <= ser_latch;
  end
  assign rise = ser_latch & ~latch_q;
  // A word ended and was dropped two cycles later.
  sequence s_dropped;
    rise ##2 word_rejected;
  endsequence
  chk_main_ce_low: assert property (!chip_enable |=> !main_loop_powered)
    else $error("main loop up while chip enable low");
  chk_aux_ce_low: assert property (!chip_enable |=> !aux_loop_powered)
    else $error("aux loop up while chip enable low");
  chk_main_normal: assert property (chip_enable && !main_loop_powerdown_bit |=> main_loop_powered)
    else $error("main loop not up");
  chk_aux_follow: assert property (chip_enable |=>
    aux_loop_powered == !$past(aux_loop_powerdown_bit))
    else $error("aux power does not follow its bit");
  chk_main_hiz: assert property (main_cp_hiz == !main_loop_powered)
    else $error("main pump float wrong");
  chk_aux_hiz: assert property (aux_cp_hiz == !aux_loop_powered)
    else $error("aux pump float wrong");
  chk_denom_upper: assert property ($past(reset_n) |->
    main_frac_denominator[FD_BITS-1:FD_LO_BITS] == $past(main_frac_denominator_hi))
    else $error("upper denominator bits wrong");
  chk_field_cause: assert property ($changed({main_loop_powerdown_bit, main_ref_divider,
    aux_loop_powerdown_bit, aux_feedback_divider}) |-> $past(rise, 2))
    else $error("field changed without a word");
  chk_reject_once: assert property (word_rejected |-> $past(rise, 2) ##1 !word_rejected)
    else $error("bad reject pulse");
  chk_drop_keep: assert property (s_dropped |-> $stable(main_ref_divider))
    else $error("dropped word changed a field");
endmodule // sdp_regs_chk

// ### dv/sdp_host_model.sv
// Purpose: Serial host that writes programming words.
// Assumes: Drives at the falling clock edge.
// Notes: Serial clock rests low between words.
`timescale 1ns/100ps
module sdp_host_model (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end
  // Shifts the top n bits MSB first, each level held two cycles, then latches.
  task automatic send(input logic [23:0] w, input int n);
    @(negedge clk);
    ser_latch = 1'b0;
    for (int i = 0; i < n; i++) begin
      ser_data = w[23-i];
      ser_clk = 1'b0;
      repeat (2) @(negedge clk);
      ser_clk = 1'b1;
      repeat (2) @(negedge clk);
    end
    ser_clk = 1'b0;
    ser_data = ~ser_data;
    repeat (2) @(negedge clk);
    ser_latch = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule // sdp_host_model

// ### dv/sdp_regs_test.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: Results settle four cycles after the latch rises.
// Notes: Inputs change at the falling edge.
`timescale 1ns/100ps
module sdp_regs_test;
  import sdp_pkg::*;
  logic clk, reset_n, ser_clk, ser_data, ser_latch, ce, auto_up;
  logic [9:0] den_hi;
  logic mpd, presc, apd, mpw, mhiz, apw, ahiz, rej;
  logic [5:0] ref_div;
  logic [21:0] fden;
  logic [18:0] an;
  int error_cnt = 0;
  int compares = 0;
  int rej_cnt = 0;
  sdp_host_model i_host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
  sdp_regs i_dut (.clk(clk), .reset_n(reset_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .chip_enable(ce), .auto_powerup_on_write(auto_up),
    .main_frac_denominator_hi(den_hi), .main_loop_powerdown_bit(mpd),
    .main_prescaler_select(presc), .main_ref_divider(ref_div), .main_frac_denominator(fden),
    .aux_loop_powerdown_bit(apd), .aux_feedback_divider(an), .main_loop_powered(mpw),
    .main_cp_hiz(mhiz), .aux_loop_powered(apw), .aux_cp_hiz(ahiz), .word_rejected(rej));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Counts dropped-word pulses.
  always @(posedge clk) if (rej === 1'b1) rej_cnt++;
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic t_main;
    i_host.send({1'b0, 1'b1, 6'h01, 12'habc, SEL_MAIN_WORD}, 24);
    chk("presc", 1, presc);
    chk("ref", 1, ref_div);
    chk("fden", {10'h2a5, 12'habc}, fden);
    chk("main_up", 1, mpw);
    i_host.send({1'b1, 1'b0, 6'h3f, 12'h001, SEL_MAIN_WORD}, 24);
    chk("ref63", 6'h3f, ref_div);
    chk("presc0", 0, presc);
    chk("main_down", 0, mpw);
    chk("main_hiz", 1, mhiz);
  endtask
  task automatic t_aux_ce;
    i_host.send({1'b0, 19'h5a5a5, SEL_AUX_WORD}, 24);
    i_host.send({1'b0, 1'b0, 6'h02, 12'h000, SEL_MAIN_WORD}, 24);
    chk("aux_n", 19'h5a5a5, an);
    chk("aux_up", 1, apw);
    ce = 1'b0;
    repeat (2) @(negedge clk);
    chk("ce_main", 0, mpw);
    chk("ce_aux", 0, apw);
    chk("ce_aux_hiz", 1, ahiz);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk("ce_back", 1, mpw);
  endtask
  task automatic t_auto;
    i_host.send({1'b1, 19'h00001, SEL_AUX_WORD}, 24);
    i_host.send({1'b1, 1'b0, 6'h05, 12'h000, SEL_MAIN_WORD}, 24);
    i_host.send(24'h000010, 24);
    chk("no_auto", 1, apd);
    auto_up = 1'b1;
    i_host.send(24'h000010, 24);
    chk("auto_apd", 0, apd);
    chk("auto_aux", 1, apw);
    chk("auto_main", 1, mpw);
    ce = 1'b0;
    repeat (2) @(negedge clk);
    chk("auto_ce", 0, mpw);
    ce = 1'b1;
    auto_up = 1'b0;
    i_host.send({1'b1, 1'b0, 6'h05, 12'h000, SEL_MAIN_WORD}, 24);
    chk("pd_rules", 0, mpw);
  endtask
  task automatic t_bad;
    i_host.send({1'b0, 1'b1, 6'h09, 12'h000, SEL_MAIN_WORD}, 20);
    chk("rej", 1, rej_cnt);
    chk("short", 6'h05, ref_div);
    i_host.send({1'b0, 1'b1, 6'h09, 12'h000, 4'h7}, 24);
    chk("other", 6'h05, ref_div);
  endtask
  task automatic results;
    $display("Compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    auto_up = 1'b0;
    den_hi = 10'h2a5;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk("rst_main", 0, mpw);
    t_main;
    t_aux_ce;
    t_auto;
    t_bad;
    results;
  end
endmodule // sdp_regs_test
bind sdp_regs sdp_regs_chk i_chk (.clk, .reset_n, .ser_latch, .chip_enable,
  .main_frac_denominator_hi, .main_loop_powerdown_bit, .main_ref_divider,
  .main_frac_denominator, .aux_loop_powerdown_bit, .aux_feedback_divider,
  .main_loop_powered, .main_cp_hiz, .aux_loop_powered, .aux_cp_hiz, .word_rejected);
